// [hdl/dsq_pkg.sv]
// Shared constants and types of the dual converter hold queue and read-out block
package dsq_pkg;
    localparam int PAIRS      = 3;
    localparam int RES_W      = 12;
    localparam int CHAN_W     = 3;
    localparam int BYTE_W     = 8;
    localparam int WORDS      = 6;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_NS     = 10;

    typedef logic [1:0]        dsq_pair_t;
    typedef logic [4:0]        dsq_cnt_t;
    typedef logic [CHAN_W-1:0] dsq_chan_t;

    localparam dsq_pair_t PAIR_A = 2'h0;
    localparam dsq_pair_t PAIR_B = 2'h1;
    localparam dsq_pair_t PAIR_C = 2'h2;

    // Conversion timing in conversion clock cycles
    localparam dsq_cnt_t BUSY_CYCLES  = 5'h0d;
    localparam dsq_cnt_t LATCH_CYCLE  = 5'h0c;
    localparam dsq_cnt_t CYCLE_CYCLES = 5'h10;

    // Address and mode codes
    localparam dsq_chan_t SEL_LAST_DIRECT = 3'h5;
    localparam dsq_chan_t SEL_CYCLE       = 3'h6;
    localparam dsq_chan_t SEL_FIFO        = 3'h7;
    localparam dsq_chan_t CHAN_FIRST      = 3'h0;

    typedef struct packed {
        logic            valid;
        dsq_chan_t       chan;
        logic [RES_W-1:0] data;
    } dsq_word_t;

    typedef struct packed {
        dsq_chan_t       chan;
        logic [RES_W-1:0] data;
    } dsq_entry_t;

    localparam int ENTRY_W = $bits(dsq_entry_t);

    typedef struct packed {
        logic      rd_n;
        logic      cs_n;
        dsq_chan_t sel;
        logic      byte_mode;
    } dsq_bus_ctl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_ACQ  = 3'b100
    } dsq_state_t;
endpackage

// [hdl/dsq_sync.sv]
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module dsq_sync #(
    parameter int        WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_reg <= INIT;
            sync_out <= INIT;
        end else begin
            meta_reg <= pin_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// [hdl/dsq_fifo.sv]
// Result FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module dsq_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             do_wr;
    logic             do_rd;

    assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/dsq_top.sv]
// Hold queue, conversion sequencer and result read-out of a dual 12-bit converter
// Behaviour
// RL1: Reset clears outputs, aborts conversion, resamples all
// RL2: Busy low thirteen cycles, rises after latch
// RL3: Conversion cycle occupies at least sixteen cycles
// RL4: Falling strobe holds pair, conversion queued
// RL5: Same-cycle strobes convert A, then B, C
// RL6: Strobe edges assigned to one clock cycle
// RL7: Strobes edge triggered, held low starts nothing
// RL8: Further edges ignored until conversion done
// RL9: Host waits 175ns after busy before hold
// RL10: Bus driven only with select and strobe low
// RL11: Result latched 12.5 cycles after busy falls; code latches 13 cycles after, on the edge busy rises
// RL12: Host holds late reads low 50ns
// RL13: Bit 15 flags valid data
// RL14: Bits 14..12 carry source channel code
// RL15: Result on bits 11..0, MSB first
// RL16: Byte mode: low byte, then high byte
// RL17: Direct codes 010/011 return B0/B1
// RL18: Works with chip select tied low
// RL19: Host avoids reads at hold edges
// RL20: Both channels of pair held and converted
// RL21: Code 110 cycles A0..C1, reset restarts
// RL22: Code 111 reads results in FIFO order
// RL23: Word mode presents full word each read
`timescale 1ns/100ps
`default_nettype none
module dsq_top (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     pair_one_hold_n,
    input  wire logic                     pair_two_hold_n,
    input  wire logic                     pair_three_hold_n,
    input  wire logic                     select_bit_2,
    input  wire logic                     select_bit_1,
    input  wire logic                     select_bit_0,
    input  wire logic                     rd_n,
    input  wire logic                     cs_n,
    input  wire logic                     byte_mode,
    input  wire logic [dsq_pkg::RES_W-1:0] conv_result_0,
    input  wire logic [dsq_pkg::RES_W-1:0] conv_result_1,
    output logic                          busy_n,
    output logic                          conv_start,
    output dsq_pkg::dsq_pair_t            conv_pair,
    output logic [dsq_pkg::PAIRS-1:0]     pair_hold,
    output dsq_pkg::dsq_word_t            data_out,
    output logic                          data_oe
);
    import dsq_pkg::*;

    logic [PAIRS-1:0] hold_n_s;
    logic [PAIRS-1:0] hold_d_reg;
    logic [PAIRS-1:0] hold_fall;
    logic [PAIRS-1:0] armed_reg;
    dsq_bus_ctl_t     ctl_s;
    dsq_pair_t        q_reg [PAIRS];
    dsq_pair_t        q_next [PAIRS];
    logic [1:0]       q_cnt_reg;
    logic [1:0]       q_cnt_next;
    dsq_state_t       state_reg;
    dsq_cnt_t         cnt_reg;
    dsq_pair_t        cur_pair_reg;
    logic [RES_W-1:0] res_reg [WORDS];
    logic [WORDS-1:0] res_valid_reg;
    dsq_entry_t       stg_reg [2];
    logic [1:0]       stg_cnt_reg;
    logic             latch_now;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    dsq_entry_t       fifo_out_data;
    logic             rd_act;
    logic             rd_act_d_reg;
    logic             rd_end;
    logic             word_done;
    logic             byte_ph_reg;
    dsq_chan_t        cyc_ptr_reg;
    dsq_word_t        sel_word;

    // Hold strobes and bus controls come from pins: synchronise before use
    dsq_sync #(
        .WIDTH (PAIRS),
        .INIT  ('1)
    ) u_hold_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .pin_in   ({pair_three_hold_n, pair_two_hold_n, pair_one_hold_n}),
        .sync_out (hold_n_s)
    );

    dsq_sync #(
        .WIDTH ($bits(dsq_bus_ctl_t)),
        .INIT  ({1'b1, 1'b1, 3'h0, 1'b0})
    ) u_ctl_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .pin_in   ({rd_n, cs_n, select_bit_2, select_bit_1, select_bit_0, byte_mode}),
        .sync_out (ctl_s)
    );

    // Edge detect on synchronised strobes; a low level alone does nothing
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hold_d_reg <= '1;
        end else begin
            hold_d_reg <= hold_n_s; // RL6
        end
    end

    assign hold_fall = hold_d_reg & ~hold_n_s & armed_reg; // RL7 RL8

    // A pair stays held from its edge until its result is latched
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            armed_reg <= '1; // RL1
        end else begin
            for (int p = 0; p < PAIRS; p++) begin
                if (hold_fall[p]) begin
                    armed_reg[p] <= 1'b0; // RL4 RL8
                end else if (latch_now && cur_pair_reg == dsq_pair_t'(p)) begin
                    armed_reg[p] <= 1'b1;
                end
            end
        end
    end

    assign pair_hold = ~armed_reg; // RL20

    assign conv_start = state_reg == ST_IDLE && q_cnt_reg != 2'h0 && stg_cnt_reg == 2'h0;
    assign conv_pair  = q_reg[0];
    assign latch_now  = state_reg == ST_CONV && cnt_reg == LATCH_CYCLE;

    // Queue of held pairs; same-cycle edges enter in A, B, C order
    always_comb begin
        int n;
        n = int'(q_cnt_reg);
        for (int i = 0; i < PAIRS; i++) begin
            q_next[i] = q_reg[i];
        end
        if (conv_start) begin
            for (int i = 0; i < PAIRS - 1; i++) begin
                q_next[i] = q_reg[i+1];
            end
            n = n - 1;
        end
        for (int p = 0; p < PAIRS; p++) begin
            if (hold_fall[p] && n < PAIRS) begin
                q_next[n] = dsq_pair_t'(p); // RL5
                n = n + 1;
            end
        end
        q_cnt_next = n[1:0];
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q_cnt_reg <= 2'h0; // RL1
            for (int i = 0; i < PAIRS; i++) begin
                q_reg[i] <= PAIR_A;
            end
        end else begin
            q_cnt_reg <= q_cnt_next; // RL4
            for (int i = 0; i < PAIRS; i++) begin
                q_reg[i] <= q_next[i];
            end
        end
    end

    // Sequencer: busy phase, then acquisition until the cycle is complete
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg    <= ST_IDLE; // RL1
            cnt_reg      <= '0;
            cur_pair_reg <= PAIR_A;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (conv_start) begin
                        state_reg    <= ST_CONV;
                        cnt_reg      <= '0;
                        cur_pair_reg <= q_reg[0];
                    end
                end
                ST_CONV: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == BUSY_CYCLES - 1'b1) begin
                        state_reg <= ST_ACQ; // RL2
                    end
                end
                ST_ACQ: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CYCLE_CYCLES - 1'b1) begin
                        state_reg <= ST_IDLE; // RL3
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign busy_n = state_reg != ST_CONV; // RL2

    // Output registers, one per channel, indexed by channel code
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_valid_reg <= '0; // RL1
            for (int i = 0; i < WORDS; i++) begin
                res_reg[i] <= '0;
            end
        end else if (latch_now) begin
            res_reg[{cur_pair_reg, 1'b0}]       <= conv_result_0; // RL11 RL20
            res_reg[{cur_pair_reg, 1'b1}]       <= conv_result_1;
            res_valid_reg[{cur_pair_reg, 1'b0}] <= 1'b1;
            res_valid_reg[{cur_pair_reg, 1'b1}] <= 1'b1;
        end
    end

    // Staging of both words into the FIFO; a full FIFO holds off the next start
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stg_cnt_reg <= 2'h0;
            stg_reg[0]  <= '0;
            stg_reg[1]  <= '0;
        end else if (latch_now) begin
            stg_cnt_reg <= 2'h2;
            stg_reg[0]  <= '{chan: {cur_pair_reg, 1'b0}, data: conv_result_0};
            stg_reg[1]  <= '{chan: {cur_pair_reg, 1'b1}, data: conv_result_1};
        end else if (stg_cnt_reg != 2'h0 && fifo_in_ready) begin
            stg_cnt_reg <= stg_cnt_reg - 1'b1;
            stg_reg[0]  <= stg_reg[1];
        end
    end

    dsq_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (stg_cnt_reg != 2'h0),
        .in_ready  (fifo_in_ready),
        .in_data   (stg_reg[0]),
        .out_valid (fifo_out_valid),
        .out_ready (word_done && ctl_s.sel == SEL_FIFO), // RL22
        .out_data  (fifo_out_data)
    );

    // Read strobe handling; chip select may simply be tied low
    assign rd_act    = !ctl_s.cs_n && !ctl_s.rd_n; // RL10 RL18
    assign rd_end    = rd_act_d_reg && !rd_act;
    assign word_done = rd_end && (!ctl_s.byte_mode || byte_ph_reg); // RL16 RL23
    assign data_oe   = rd_act; // RL10

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_act_d_reg <= 1'b0;
        end else begin
            rd_act_d_reg <= rd_act;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            byte_ph_reg <= 1'b0;
        end else if (!ctl_s.byte_mode) begin
            byte_ph_reg <= 1'b0;
        end else if (rd_end) begin
            byte_ph_reg <= !byte_ph_reg; // RL16
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cyc_ptr_reg <= CHAN_FIRST; // RL21
        end else if (word_done && ctl_s.sel == SEL_CYCLE) begin
            if (cyc_ptr_reg == SEL_LAST_DIRECT) begin
                cyc_ptr_reg <= CHAN_FIRST;
            end else begin
                cyc_ptr_reg <= cyc_ptr_reg + 1'b1; // RL21
            end
        end
    end

    // Word selection by address/mode code
    always_comb begin
        dsq_chan_t ch;
        ch = ctl_s.sel;
        if (ctl_s.sel == SEL_CYCLE) begin
            ch = cyc_ptr_reg;
        end
        sel_word = '{valid: res_valid_reg[ch], chan: ch, data: res_reg[ch]}; // RL14 RL15 RL17
        if (ctl_s.sel == SEL_FIFO) begin
            sel_word = '{valid: fifo_out_valid, chan: fifo_out_data.chan,
                         data: fifo_out_data.data}; // RL13 RL22
        end
    end

    // Data leaves from a register; refreshed every cycle so late results show
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            data_out <= '0; // RL1
        end else if (ctl_s.byte_mode && !byte_ph_reg) begin
            data_out <= dsq_word_t'({BYTE_W'(0), sel_word[BYTE_W-1:0]}); // RL16
        end else if (ctl_s.byte_mode) begin
            data_out <= dsq_word_t'({BYTE_W'(0), sel_word[2*BYTE_W-1:BYTE_W]});
        end else begin
            data_out <= sel_word; // RL23
        end
    end

    // Helper counters for the checks below
    dsq_cnt_t lo_cnt_reg;
    dsq_cnt_t gap_cnt_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst || busy_n) begin
            lo_cnt_reg <= '0;
        end else if (lo_cnt_reg != '1) begin
            lo_cnt_reg <= lo_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // Reset aborts the cycle, so a start right after it is legal
            gap_cnt_reg <= CYCLE_CYCLES;
        end else if (conv_start) begin
            gap_cnt_reg <= 5'h01;
        end else if (gap_cnt_reg != '1) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
        end
    end

    sequence s_start_of(dsq_pair_t p);
        conv_start && conv_pair == p;
    endsequence

    sequence s_latched(dsq_pair_t p);
        ##13 (!busy_n && latch_now)
        ##1 (busy_n && res_valid_reg[{p, 1'b0}] && res_valid_reg[{p, 1'b1}]);
    endsequence

    AST_BUSY_LOW_13: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL2
        $rose(busy_n) |-> lo_cnt_reg == BUSY_CYCLES)
        else $error("busy low time wrong");
    AST_CYCLE_16: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL3
        conv_start |-> gap_cnt_reg >= CYCLE_CYCLES)
        else $error("conversions closer than a full cycle");
    AST_LATCH_BEFORE_BUSY: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL11
        s_start_of(conv_pair) |-> s_latched(cur_pair_reg))
        else $error("result not latched when busy rises");
    AST_BUS_ENABLE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL10
        data_oe == (!$past(cs_n, 2) && !$past(rd_n, 2)))
        else $error("bus driven without select and strobe");
    AST_ORDER_A_FIRST: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL5
        (hold_fall[0] && hold_fall[1] && q_cnt_reg == {1'b0, conv_start})
        |=> (q_reg[0] == PAIR_A && q_reg[1] == PAIR_B))
        else $error("same-cycle holds queued out of order");
    AST_HELD_WHILE_QUEUED: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL4
        conv_start |-> pair_hold[conv_pair] ##1 pair_hold[cur_pair_reg][*8])
        else $error("pair not held during conversion");
    AST_LEVEL_NO_START: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL7
        ($past(!hold_n_s[1]) && !hold_n_s[1]) |-> !hold_fall[1])
        else $error("low level started a conversion");
    AST_RESET_CLEARS: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL1
        $fell(sys_rst) |-> (busy_n && pair_hold == '0 && res_valid_reg == '0 && !data_out.valid))
        else $error("reset left state behind");
    AST_CYCLE_WRAP: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL21
        (word_done && ctl_s.sel == SEL_CYCLE && cyc_ptr_reg == SEL_LAST_DIRECT)
        |=> cyc_ptr_reg == CHAN_FIRST)
        else $error("cycle mode did not wrap to first channel");
    AST_BYTE_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL16
        ($past(ctl_s.byte_mode) && ctl_s.byte_mode) |-> data_out[15:8] == '0)
        else $error("byte mode drove upper bits");
endmodule
`default_nettype wire

// [tb/dsq_conv_model.sv]
// Converter pair model answering each started conversion with a traceable result
`timescale 1ns/100ps
`default_nettype none
module dsq_conv_model (
    input  wire logic                      ref_clk,
    input  wire logic                      sys_rst,
    input  wire logic                      conv_start,
    input  wire dsq_pkg::dsq_pair_t        conv_pair,
    input  wire logic                      busy_n,
    output logic [dsq_pkg::RES_W-1:0]      conv_result_0,
    output logic [dsq_pkg::RES_W-1:0]      conv_result_1
);
    import dsq_pkg::*;

    logic [7:0]       seq_reg;
    logic [RES_W-1:0] res_reg;

    // Result encodes pair and start count so every latched word is predictable
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            seq_reg <= 8'h00;
            res_reg <= 12'h5a5;
        end else if (conv_start) begin
            seq_reg <= seq_reg + 8'h01;
            res_reg <= {conv_pair, 2'h0, seq_reg};
        end else if (busy_n) begin
            // Outside a conversion the value is junk that moves every cycle
            res_reg <= ~res_reg;
        end
    end

    // Both halves of the pair come from one start, one per converter
    assign conv_result_0 = res_reg;
    assign conv_result_1 = res_reg ^ 12'h0ff;
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for hold queueing, conversion sequencing and read-out
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module testbench;
    import dsq_pkg::*;

    logic             ref_clk   = 1'b0;
    logic             sys_rst   = 1'b1;
    logic [2:0]       hold_n    = 3'h7;
    logic [2:0]       sel       = 3'h0;
    logic             rd_n      = 1'b1;
    logic             cs_n      = 1'b0;
    logic             byte_mode = 1'b0;
    logic [RES_W-1:0] res0;
    logic [RES_W-1:0] res1;
    logic             busy_n;
    logic             conv_start;
    logic             data_oe;
    dsq_pair_t        conv_pair;
    logic [PAIRS-1:0] pair_hold;
    dsq_word_t        data_out;
    int               n_mismatch  = 0;
    int               check_count = 0;
    int               cyc         = 0;
    int               blen        = 0;
    int               st_cyc[$];
    dsq_pair_t        st_pair[$];
    int               busy_len[$];
    logic [7:0]       conv_n = 8'h00;
    dsq_word_t        last_w[WORDS];
    dsq_word_t        fifo_q[$];
    dsq_word_t        rd_w;
    dsq_pair_t        exp_order[3] = '{PAIR_C, PAIR_A, PAIR_B};

    always #(CLK_NS / 2) ref_clk = ~ref_clk;

    dsq_top dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .pair_one_hold_n(hold_n[0]), .pair_two_hold_n(hold_n[1]),
        .pair_three_hold_n(hold_n[2]),
        .select_bit_2(sel[2]), .select_bit_1(sel[1]), .select_bit_0(sel[0]),
        .rd_n(rd_n), .cs_n(cs_n), .byte_mode(byte_mode),
        .conv_result_0(res0), .conv_result_1(res1),
        .busy_n(busy_n), .conv_start(conv_start), .conv_pair(conv_pair),
        .pair_hold(pair_hold), .data_out(data_out), .data_oe(data_oe)
    );

    dsq_conv_model conv (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .conv_start(conv_start),
        .conv_pair(conv_pair), .busy_n(busy_n),
        .conv_result_0(res0), .conv_result_1(res1)
    );

    // Logs every start and every busy-low stretch in pre-edge values
    always @(posedge ref_clk) begin
        cyc++;
        if (conv_start === 1'b1 && !sys_rst) begin
            st_cyc.push_back(cyc);
            st_pair.push_back(conv_pair);
        end
        if (busy_n === 1'b0) begin
            blen++;
        end else if (blen != 0) begin
            busy_len.push_back(blen);
            blen = 0;
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic fail_wait(input string what);
        $display("mismatch %s expected done seen timeout", what);
        n_mismatch++;
        tally_and_finish();
    endtask

    task automatic step(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    function automatic dsq_word_t conv_word(dsq_pair_t p, logic half, logic [7:0] n);
        logic [RES_W-1:0] v;
        v = {p, 2'h0, n};
        if (half)
            v = v ^ 12'h0ff;
        return '{1'b1, {p, half}, v};
    endfunction

    task automatic note_conv(input dsq_pair_t p);
        last_w[{p, 1'b0}] = conv_word(p, 1'b0, conv_n);
        last_w[{p, 1'b1}] = conv_word(p, 1'b1, conv_n);
        fifo_q.push_back(last_w[{p, 1'b0}]);
        fifo_q.push_back(last_w[{p, 1'b1}]);
        conv_n++;
    endtask

    task automatic wait_done(input int starts);
        int i;
        for (i = 0; i < 600; i++) begin
            if (st_pair.size() >= starts && busy_n === 1'b1 && pair_hold === 3'h0)
                break;
            step();
        end
        if (i == 600)
            fail_wait("conversion_done");
        step(2);
    endtask

    // Reads only while hold pins are steady, so no sample is disturbed
    task automatic read_word(input logic [2:0] s, output dsq_word_t w);
        int i;
        sel = s;
        step();
        rd_n = 1'b0;
        for (i = 0; i < 10 && data_oe !== 1'b1; i++)
            step();
        if (i == 10)
            fail_wait("read_enable");
        step(3);
        w = data_out;
        rd_n = 1'b1;
        for (i = 0; i < 10 && data_oe !== 1'b0; i++)
            step();
        if (i == 10)
            fail_wait("read_release");
        step(3);
    endtask

    initial begin
        int k;
        step(10);
        sys_rst = 1'b0;
        step();
        `CHK("busy_n", 1'b1, busy_n)
        `CHK("pair_hold", 3'h0, pair_hold)
        `CHK("data_out", 16'h0000, data_out)
        cs_n = 1'b1;
        rd_n = 1'b0;
        step(4);
        `CHK("oe_select_high", 1'b0, data_oe)
        rd_n = 1'b1;
        cs_n = 1'b0;
        step(4);
        `CHK("oe_strobe_high", 1'b0, data_oe)
        $display("test reset_and_bus done");

        hold_n[1] = 1'b0;
        step(3);
        hold_n[1] = 1'b1;
        step(3);
        `CHK("pair_b_held", 3'h2, pair_hold)
        wait_done(1);
        note_conv(PAIR_B);
        `CHK("first_pair", PAIR_B, st_pair[0])
        `CHK("busy_low_cycles", 13, busy_len[0])
        read_word(3'h2, rd_w);
        `CHK("direct_b0", last_w[2], rd_w)
        read_word(3'h3, rd_w);
        `CHK("direct_b1", last_w[3], rd_w)
        $display("test single_conversion done");

        step(20);
        st_pair.delete();
        st_cyc.delete();
        busy_len.delete();
        hold_n[2] = 1'b0;
        step();
        hold_n[1:0] = 2'b00;
        step(8);
        hold_n[0] = 1'b1;
        step(3);
        hold_n[0] = 1'b0;
        wait_done(3);
        step(60);
        `CHK("start_count", 3, st_pair.size())
        for (k = 0; k < 3; k++) begin
            `CHK("queue_order", exp_order[k], st_pair[k])
            `CHK("busy_len", 13, busy_len[k])
            note_conv(exp_order[k]);
        end
        for (k = 1; k < 3; k++) begin
            `CHK("start_spacing", 1'b1, (st_cyc[k] - st_cyc[k-1]) >= 16)
        end
        hold_n = 3'h7;
        $display("test queue_order done");

        for (k = 0; k < 8; k++) begin
            read_word(SEL_FIFO, rd_w);
            `CHK("fifo_word", fifo_q[k], rd_w)
        end
        read_word(SEL_FIFO, rd_w);
        `CHK("fifo_empty_flag", 1'b0, rd_w.valid)
        $display("test fifo_mode done");

        for (k = 0; k < 7; k++) begin
            read_word(SEL_CYCLE, rd_w);
            `CHK("cycle_word", last_w[k % 6], rd_w)
        end
        $display("test cycle_mode done");

        byte_mode = 1'b1;
        read_word(3'h0, rd_w);
        `CHK("byte_low", {8'h00, last_w[0][7:0]}, rd_w)
        read_word(3'h0, rd_w);
        `CHK("byte_high", {8'h00, last_w[0][15:8]}, rd_w)
        byte_mode = 1'b0;
        read_word(3'h0, rd_w);
        `CHK("word_full", last_w[0], rd_w)
        $display("test byte_mode done");

        step(20);
        st_pair.delete();
        hold_n[0] = 1'b0;
        step(3);
        hold_n[0] = 1'b1;
        for (k = 0; k < 20 && st_pair.size() == 0; k++)
            step();
        if (k == 20)
            fail_wait("abort_start");
        step(4);
        sys_rst = 1'b1;
        step(3);
        sys_rst = 1'b0;
        step();
        conv_n = 8'h00;
        `CHK("abort_busy_n", 1'b1, busy_n)
        `CHK("abort_pair_hold", 3'h0, pair_hold)
        read_word(3'h0, rd_w);
        `CHK("cleared_valid", 1'b0, rd_w.valid)
        st_pair.delete();
        hold_n[0] = 1'b0;
        step(3);
        hold_n[0] = 1'b1;
        wait_done(1);
        note_conv(PAIR_A);
        read_word(SEL_CYCLE, rd_w);
        `CHK("cycle_restart", last_w[0], rd_w)
        $display("test reset_abort done");
        tally_and_finish();
    end
endmodule
`undef CHK
`default_nettype wire
